// ==== bench/mac_model.sv ====
`timescale 1ns/10ps
module mac_model (
  // link clock and the nibble clock from the phy
  input wire logic ref_clk,
  input wire logic tx_clk,
  // transmit pins toward the phy
  output logic tx_en,
  output logic tx_er,
  output logic [3:0] txd
);
  import phy_port_pkg::*;

  // expected line records, popped by the bench monitor
  logic [8:0] exp_q[$];
  int seed = 32'h35b95223;

  ////////////////////////////////////////////////////////////////////////////
  // idle pins until a frame is sent
  initial begin
    tx_en = 1'b0;
    tx_er = 1'b0;
    txd = 4'h0;
  end

  // one frame; junk leaves non-zero data behind with the enable low
  task automatic send_frame(input int n, input logic rmii, input int err_at, input logic junk);
    logic [3:0] nib;
    for (int i = 0; i < n; i++) begin
      nib = (i == 0) ? NIB_PRE : 4'($random(seed));
      exp_q.push_back({(i == err_at && !rmii) ? CODE_H : CODE_NONE, nib});
      if (rmii) begin
        // low di-bit first, upper pins stay grounded
        @(posedge ref_clk);
        #1;
        tx_en = 1'b1;
        txd = {2'h0, nib[1:0]};
        @(posedge ref_clk);
        #1;
        txd = {2'h0, nib[3:2]};
      end else begin
        // change just after the nibble clock falls, so the rise samples it
        @(negedge tx_clk);
        #1;
        tx_en = 1'b1;
        tx_er = (i == err_at);
        txd = nib;
      end
    end
    if (rmii) @(posedge ref_clk);
    else @(negedge tx_clk);
    #1;
    tx_en = 1'b0;
    tx_er = 1'b0;
    txd = junk ? (rmii ? 4'h3 : 4'h9) : 4'h0;
    repeat (8) @(posedge ref_clk);
    #1;
    txd = 4'h0;
  endtask : send_frame
endmodule : mac_model

// ==== bench/tb_phy_data_port.sv ====
`timescale 1ns/10ps
module tb_phy_data_port;
  import phy_port_pkg::*;

  logic core_clk = 1'b0;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic cfg_rmii = 1'b0;
  logic speed_100 = 1'b1;
  logic half_dup = 1'b0;
  logic link_up = 1'b1;
  logic an_en = 1'b0;
  logic carrier = 1'b0;
  logic sym_valid = 1'b0;
  sym_e sym_kind = SYM_IDLE;
  logic [3:0] sym_nib = 4'h0;
  logic sym_ready, tx_valid, tx_active, coll, rx_line, ntc, nrc;
  logic mac_tx_en, mac_tx_er, rx_dv, rx_er, crs;
  logic [3:0] tx_nib, mac_txd, rxd, nib, prev;
  logic [4:0] tx_code;
  logic [6:0] rx_last = 7'h0;
  logic [6:0] rx_cur, rx_exp;
  logic [6:0] rx_q[$];
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 32'h35b95223;

  ////////////////////////////////////////////////////////////////////////////
  // core clock, and a link clock of unrelated phase that never stops
  initial forever #5 core_clk = ~core_clk;
  initial begin
    #3;
    forever #62.5 ref_clk = ~ref_clk;
  end

  phy_data_port phy_data_port_inst (
    .core_clk(core_clk), .rstn(rstn), .clk_en(1'b1), .cfg_rmii(cfg_rmii),
    .line_speed_100(speed_100), .line_half_duplex(half_dup), .line_link_up(link_up),
    .line_autoneg_en(an_en), .line_carrier_det(carrier), .rx_sym_valid(sym_valid),
    .rx_sym_kind(sym_kind), .rx_sym_nibble(sym_nib), .rx_sym_ready(sym_ready),
    .tx_line_valid(tx_valid), .tx_line_nibble(tx_nib), .tx_line_code(tx_code),
    .tx_line_active(tx_active), .collision(coll), .rx_clk_from_line(rx_line),
    .reference_oscillator_input(ref_clk), .nibble_transmit_clock(ntc),
    .nibble_receive_clock(nrc), .mac_tx_en(mac_tx_en), .mac_tx_er(mac_tx_er),
    .mac_txd(mac_txd), .mac_rx_dv(rx_dv), .mac_rx_er(rx_er), .mac_crs(crs), .mac_rxd(rxd));

  mac_model mac_model_inst (
    .ref_clk(ref_clk), .tx_clk(ntc), .tx_en(mac_tx_en), .tx_er(mac_tx_er), .txd(mac_txd));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_rec(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : chk_rec

  task automatic end_sim;
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // reset must cover several slow link edges, so count those
  task automatic do_reset(input logic rmii);
    rstn = 1'b0;
    cfg_rmii = rmii;
    rx_last = 7'h0;
    repeat (8) @(posedge ref_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    repeat (10) @(posedge ref_clk);
    @(negedge core_clk);
  endtask : do_reset

  // f is {valid, error, carrier}; data only matters while valid
  task automatic exp_rx(input logic [2:0] f, input logic [3:0] n);
    rx_q.push_back({f, f[2] ? n : 4'h0});
  endtask : exp_rx

  // hold the symbol until ready was seen, then leave time for the pins
  task automatic send_sym(input sym_e k, input logic [3:0] n);
    sym_valid = 1'b1;
    sym_kind = k;
    sym_nib = n;
    // a stuck ready is left to the hang guard
    while (sym_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    sym_valid = 1'b0;
    repeat (6) @(posedge ref_clk);
    @(negedge core_clk);
  endtask : send_sym

  ////////////////////////////////////////////////////////////////////////////
  // receive monitor: every change seen at the nibble clock rise is a record
  always @(posedge nrc) begin
    rx_cur = {rx_dv, rx_er, crs, rx_dv ? rxd : 4'h0};
    if (rx_cur !== rx_last) begin
      rx_last = rx_cur;
      if (rx_q.size() == 0) chk_rec("rx extra", 9'h1ff, {2'h0, rx_cur});
      else begin
        rx_exp = rx_q.pop_front();
        chk_rec("rx record", {2'h0, rx_exp}, {2'h0, rx_cur});
      end
    end
  end

  // transmit monitor: each pulse takes the oldest note of the mac model
  always @(posedge core_clk) begin
    if (tx_valid === 1'b1) begin
      if (mac_model_inst.exp_q.size() == 0) chk_rec("tx extra", 9'h1ff, {tx_code, tx_nib});
      else chk_rec("tx nibble", mac_model_inst.exp_q.pop_front(), {tx_code, tx_nib});
    end
  end

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'b0);
    half_dup = 1'b1;
    exp_rx(3'b101, NIB_PRE);
    send_sym(SYM_JK, 4'h0);
    fork
      mac_model_inst.send_frame(10, 1'b0, 7, 1'b1);
    join_none
    repeat (60) @(negedge core_clk);
    chk_rec("collision", 9'h1, {8'h0, coll});
    chk_rec("tx active", 9'h1, {8'h0, tx_active});
    prev = NIB_PRE;
    for (int i = 0; i < 6; i++) begin
      nib = 4'($random(seed));
      if (nib == prev) nib = nib ^ 4'h1;
      prev = nib;
      exp_rx(3'b101, nib);
      send_sym(SYM_DATA, nib);
    end
    exp_rx(3'b111, NIB_ERR);
    send_sym(SYM_ERR, 4'h3);
    exp_rx(3'b000, 4'h0);
    send_sym(SYM_TR, 4'h0);
    wait fork;
    repeat (40) @(negedge core_clk);
    chk_rec("collision", 9'h0, {8'h0, coll});
    chk_rec("tx active", 9'h0, {8'h0, tx_active});
    // idle inside a frame: one errored record, then quiet
    exp_rx(3'b101, NIB_PRE);
    send_sym(SYM_JK, 4'h0);
    exp_rx(3'b010, 4'h0);
    send_sym(SYM_IDLE, 4'h0);
    exp_rx(3'b000, 4'h0);
    send_sym(SYM_IDLE, 4'h0);
    for (int i = 0; i < 3; i++) begin
      link_up = (i == 0);
      an_en = (i == 2);
      repeat (10) @(negedge core_clk);
      chk_rec("rx clock source", {8'h0, i != 1}, {8'h0, rx_line});
    end
    link_up = 1'b1;
    // slow link: preamble hidden, valid starts with the delimiter
    speed_100 = 1'b0;
    exp_rx(3'b001, 4'h0);
    repeat (3) send_sym(SYM_DATA, NIB_PRE);
    exp_rx(3'b101, NIB_PRE);
    send_sym(SYM_DATA, NIB_SFD);
    exp_rx(3'b101, NIB_SFD);
    send_sym(SYM_DATA, 4'h2);
    chk_rec("rx clock source", 9'h1, {8'h0, rx_line});
    exp_rx(3'b101, 4'h2);
    send_sym(SYM_TR, 4'h0);
    exp_rx(3'b000, 4'h0);
    send_sym(SYM_IDLE, 4'h0);
    chk_rec("rx clock source", 9'h0, {8'h0, rx_line});
    // di-bit path
    do_reset(1'b1);
    speed_100 = 1'b1;
    carrier = 1'b1;
    // carrier crosses one core flop and three link flops before it shows
    repeat (50) @(negedge core_clk);
    chk_rec("crs_dv rise", 9'h1, {8'h0, rx_dv});
    chk_rec("rxd at rise", 9'h0, {5'h0, rxd});
    fork
      mac_model_inst.send_frame(6, 1'b1, 99, 1'b1);
    join_none
    repeat (60) @(negedge core_clk);
    chk_rec("rmii flags", 9'h0, {6'h0, ntc, crs, coll});
    wait fork;
    carrier = 1'b0;
    repeat (50) @(negedge core_clk);
    chk_rec("crs_dv fall", 9'h0, {4'h0, rx_dv, rxd});
    chk_rec("pending", 9'h0, 9'(rx_q.size() + mac_model_inst.exp_q.size()));
    end_sim();
  end
endmodule : tb_phy_data_port

// ==== core/phy_data_port.sv ====
`timescale 1ns/10ps
module phy_data_port (
  // core clock, reset and enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // static strap: high selects the di-bit path
  input wire logic cfg_rmii,
  // line status from the coding layer
  input wire logic line_speed_100,
  input wire logic line_half_duplex,
  input wire logic line_link_up,
  input wire logic line_autoneg_en,
  input wire logic line_carrier_det,
  // received symbols from the coding layer
  input wire logic rx_sym_valid,
  input wire phy_port_pkg::sym_e rx_sym_kind,
  input wire logic [3:0] rx_sym_nibble,
  output logic rx_sym_ready,
  // transmit nibbles toward the coding layer
  output logic tx_line_valid,
  output logic [3:0] tx_line_nibble,
  output logic [4:0] tx_line_code,
  output logic tx_line_active,
  // line status outputs
  output logic collision,
  output logic rx_clk_from_line,
  // mac side, on the link clock
  input wire logic reference_oscillator_input,
  output logic nibble_transmit_clock,
  output logic nibble_receive_clock,
  input wire logic mac_tx_en,
  input wire logic mac_tx_er,
  input wire logic [3:0] mac_txd,
  output logic mac_rx_dv,
  output logic mac_rx_er,
  output logic mac_crs,
  output logic [3:0] mac_rxd
);
  import phy_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // core domain

  logic rst_s1_ff, rst_n_ff;
  logic strap_s1_ff, strap_s2_ff, rmii_ff;
  logic [1:0] strap_cnt_ff;
  rx_state_e state_ff, nxt_state;
  logic sfd_seen_ff, sfd_hit, accept;
  logic c_dv, c_er, c_crs;
  logic [3:0] c_nib;
  logic d_dv_ff, d_er_ff, d_crs_ff;
  logic [3:0] d_nib_ff;
  logic rec_dv_ff, rec_er_ff, rec_crs_ff, rq_tgl_ff;
  logic [3:0] rec_nib_ff;
  logic ack_s1_ff, ack_s2_ff, ready_ff, car_ff;
  logic tw_s1_ff, tw_s2_ff, tw_seen_ff, act_s1_ff, act_s2_ff;
  logic txv_ff, txa_ff, col_ff, rxsrc_ff;
  logic [3:0] txn_ff;
  logic [4:0] txc_ff;
  // link domain signals read here
  logic tw_tgl_ff, tx_act_ff, rq_seen_ff, tw_er_ff;
  logic [3:0] tw_nib_ff;

  // reset release through two flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  // strap is caught on the third enabled edge, once the sync flops hold it, then never moves
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      strap_s1_ff <= 1'b0;
      strap_s2_ff <= 1'b0;
      rmii_ff <= 1'b0;
      strap_cnt_ff <= 2'h0;
    end else if (clk_en) begin
      strap_s1_ff <= cfg_rmii;
      strap_s2_ff <= strap_s1_ff;
      if (strap_cnt_ff != 2'h3) begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
      if (strap_cnt_ff == 2'h2) begin
        rmii_ff <= strap_s2_ff;
      end
    end
  end

  assign accept = rx_sym_valid && ready_ff && clk_en;

  // framing decisions for the symbol on offer
  always_comb begin
    nxt_state = state_ff;
    c_nib = rx_sym_nibble;
    c_dv = 1'b0;
    c_er = 1'b0;
    c_crs = (state_ff == RX_FRAME);
    sfd_hit = !line_speed_100 && state_ff == RX_FRAME && !sfd_seen_ff &&
              rx_sym_kind == SYM_DATA && rx_sym_nibble == NIB_SFD && d_nib_ff == NIB_PRE;
    if (line_speed_100) begin
      unique case (state_ff)
        RX_IDLE: if (rx_sym_kind == SYM_JK) begin
          nxt_state = RX_FRAME;
          c_crs = 1'b1;
          c_dv = 1'b1;
          c_nib = NIB_PRE;
        end
        RX_FRAME: begin
          c_dv = 1'b1;
          if (rx_sym_kind == SYM_TR) begin
            nxt_state = RX_IDLE;
            c_crs = 1'b0;
            c_dv = 1'b0;
            c_nib = NIB_IDLE;
          end else if (rx_sym_kind == SYM_IDLE) begin
            nxt_state = RX_IDLE;
            c_crs = 1'b0;
            c_dv = 1'b0;
            c_er = 1'b1;
            c_nib = NIB_IDLE;
          end else if (rx_sym_kind == SYM_ERR) begin
            c_er = 1'b1;
            c_nib = NIB_ERR;
          end
        end
      endcase
    end else begin
      unique case (state_ff)
        RX_IDLE: if (rx_sym_kind == SYM_DATA && rx_sym_nibble == NIB_PRE) begin
          nxt_state = RX_FRAME;
          c_crs = 1'b1;
        end
        RX_FRAME: begin
          c_dv = sfd_seen_ff || sfd_hit;
          if (rx_sym_kind == SYM_TR) begin
            nxt_state = RX_IDLE;
            c_crs = 1'b0;
            c_dv = 1'b0;
            c_nib = NIB_IDLE;
          end else if (rx_sym_kind == SYM_ERR) begin
            c_er = 1'b1;
            c_nib = NIB_ERR;
          end
        end
      endcase
    end
  end

  // 10t runs one symbol late so the 5 ahead of the d can be marked valid
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= RX_IDLE;
      sfd_seen_ff <= 1'b0;
      {d_dv_ff, d_er_ff, d_crs_ff, d_nib_ff} <= '0;
      {rec_dv_ff, rec_er_ff, rec_crs_ff, rec_nib_ff} <= '0;
      rq_tgl_ff <= 1'b0;
    end else if (accept) begin
      state_ff <= nxt_state;
      sfd_seen_ff <= (nxt_state == RX_FRAME) && (sfd_seen_ff || sfd_hit);
      {d_dv_ff, d_er_ff, d_crs_ff, d_nib_ff} <= {c_dv, c_er, c_crs, c_nib};
      if (line_speed_100) begin
        {rec_dv_ff, rec_er_ff, rec_crs_ff, rec_nib_ff} <= {c_dv, c_er, c_crs, c_nib};
      end else begin
        {rec_dv_ff, rec_er_ff, rec_crs_ff, rec_nib_ff} <=
          {d_dv_ff || sfd_hit, d_er_ff, d_crs_ff, d_nib_ff};
      end
      rq_tgl_ff <= !rq_tgl_ff;
    end
  end

  // handshake back from the link side; the record holds until it is taken
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else if (clk_en) begin
      ack_s1_ff <= rq_seen_ff;
      ack_s2_ff <= ack_s1_ff;
      ready_ff <= !accept && (ack_s2_ff == rq_tgl_ff);
    end
  end

  // transmit words and activity from the link side
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      {tw_s1_ff, tw_s2_ff, tw_seen_ff, act_s1_ff, act_s2_ff} <= '0;
      {txv_ff, txa_ff, txn_ff, txc_ff} <= '0;
    end else if (clk_en) begin
      tw_s1_ff <= tw_tgl_ff;
      tw_s2_ff <= tw_s1_ff;
      act_s1_ff <= tx_act_ff;
      act_s2_ff <= act_s1_ff;
      txa_ff <= act_s2_ff;
      txv_ff <= tw_s2_ff != tw_seen_ff;
      if (tw_s2_ff != tw_seen_ff) begin
        tw_seen_ff <= tw_s2_ff;
        txn_ff <= tw_nib_ff;
        // tx error pin is grounded in di-bit mode, so it is not trusted there
        txc_ff <= (tw_er_ff && !rmii_ff) ? CODE_H : CODE_NONE;
      end
    end
  end

  // collision and receive clock source; collision is a plain level, not clock aligned
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      col_ff <= 1'b0;
      rxsrc_ff <= 1'b0;
      car_ff <= 1'b0;
    end else if (clk_en) begin
      col_ff <= line_half_duplex && !rmii_ff && act_s2_ff && state_ff == RX_FRAME;
      rxsrc_ff <= line_speed_100 ? (line_link_up || line_autoneg_en)
                                 : (state_ff == RX_FRAME);
      car_ff <= line_carrier_det;
    end
  end

  assign rx_sym_ready = ready_ff;
  assign tx_line_valid = txv_ff;
  assign tx_line_nibble = txn_ff;
  assign tx_line_code = txc_ff;
  assign tx_line_active = txa_ff;
  assign collision = col_ff;
  assign rx_clk_from_line = rxsrc_ff;

  ////////////////////////////////////////////////////////////////////////////
  // link domain

  logic lrst_s1_ff, lrst_n_ff, ce_s1_ff, l_ce_ff, md_s1_ff, l_rmii_ff;
  logic rq_s1_ff, rq_s2_ff, lc_s1_ff, lc_s2_ff, ph_ff, hi_ff, hi_er_ff, pair_ff;
  logic odv_ff, oer_ff, ocrs_ff;
  logic [1:0] hi_bits_ff, tlo_ff;
  logic [3:0] orxd_ff;

  always_ff @(posedge reference_oscillator_input or negedge rstn) begin
    if (!rstn) begin
      lrst_s1_ff <= 1'b0;
      lrst_n_ff <= 1'b0;
    end else begin
      lrst_s1_ff <= 1'b1;
      lrst_n_ff <= lrst_s1_ff;
    end
  end

  // level crossings into the link domain
  always_ff @(posedge reference_oscillator_input or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      {ce_s1_ff, l_ce_ff, md_s1_ff, l_rmii_ff} <= '0;
      {rq_s1_ff, rq_s2_ff, lc_s1_ff, lc_s2_ff} <= '0;
    end else begin
      ce_s1_ff <= clk_en;
      l_ce_ff <= ce_s1_ff;
      md_s1_ff <= rmii_ff;
      l_rmii_ff <= md_s1_ff;
      rq_s1_ff <= rq_tgl_ff;
      rq_s2_ff <= rq_s1_ff;
      lc_s1_ff <= car_ff;
      lc_s2_ff <= lc_s1_ff;
    end
  end

  // receive side: nibbles on the falling nibble clock, di-bits every edge
  always_ff @(posedge reference_oscillator_input or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      {ph_ff, hi_ff, hi_er_ff, hi_bits_ff, rq_seen_ff} <= '0;
      {odv_ff, oer_ff, ocrs_ff, orxd_ff} <= '0;
    end else if (l_ce_ff) begin
      if (!l_rmii_ff) begin
        ph_ff <= !ph_ff;
        if (ph_ff && rq_s2_ff != rq_seen_ff) begin
          rq_seen_ff <= rq_s2_ff;
          {odv_ff, oer_ff, ocrs_ff, orxd_ff} <=
            {rec_dv_ff, rec_er_ff, rec_crs_ff, rec_nib_ff};
        end
      end else begin
        ph_ff <= 1'b0;
        ocrs_ff <= 1'b0;
        odv_ff <= lc_s2_ff;
        if (hi_ff) begin
          hi_ff <= 1'b0;
          oer_ff <= hi_er_ff;
          orxd_ff <= {2'b00, lc_s2_ff ? hi_bits_ff : DIBIT_IDLE};
        end else if (rq_s2_ff != rq_seen_ff) begin
          rq_seen_ff <= rq_s2_ff;
          hi_ff <= 1'b1;
          hi_er_ff <= rec_er_ff;
          hi_bits_ff <= (lc_s2_ff && rec_dv_ff) ? rec_nib_ff[3:2] : DIBIT_IDLE;
          oer_ff <= rec_er_ff;
          orxd_ff <= {2'b00, (lc_s2_ff && rec_dv_ff) ? rec_nib_ff[1:0] : DIBIT_IDLE};
        end else begin
          oer_ff <= 1'b0;
          orxd_ff <= NIB_IDLE;
        end
      end
    end
  end

  // transmit side: nibble sampled where the nibble clock rises, di-bits paired low first
  always_ff @(posedge reference_oscillator_input or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      {tx_act_ff, tw_tgl_ff, tw_er_ff, tw_nib_ff, pair_ff, tlo_ff} <= '0;
    end else if (l_ce_ff) begin
      if (!l_rmii_ff) begin
        pair_ff <= 1'b0;
        if (!ph_ff) begin
          tx_act_ff <= mac_tx_en;
          if (mac_tx_en) begin
            tw_nib_ff <= mac_txd;
            tw_er_ff <= mac_tx_er;
            tw_tgl_ff <= !tw_tgl_ff;
          end
        end
      end else begin
        tx_act_ff <= mac_tx_en;
        if (!mac_tx_en) begin
          pair_ff <= 1'b0;
        end else if (!pair_ff) begin
          tlo_ff <= mac_txd[1:0];
          pair_ff <= 1'b1;
        end else begin
          tw_nib_ff <= {mac_txd[1:0], tlo_ff};
          tw_er_ff <= 1'b0;
          tw_tgl_ff <= !tw_tgl_ff;
          pair_ff <= 1'b0;
        end
      end
    end
  end

  assign nibble_transmit_clock = ph_ff;
  assign nibble_receive_clock = ph_ff;
  assign mac_rx_dv = odv_ff;
  assign mac_rx_er = oer_ff;
  assign mac_crs = ocrs_ff;
  assign mac_rxd = orxd_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_err_nibble: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    accept && line_speed_100 && state_ff == RX_FRAME && rx_sym_kind == SYM_ERR
    |=> rec_er_ff && rec_nib_ff == NIB_ERR)
    else $error("error symbol not flagged");
  a_jk_carrier: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    accept && line_speed_100 && state_ff == RX_IDLE && rx_sym_kind == SYM_JK
    |=> state_ff == RX_FRAME && rec_crs_ff && rec_dv_ff)
    else $error("j/k did not start carrier");
  a_idle_abort: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    accept && line_speed_100 && state_ff == RX_FRAME && rx_sym_kind == SYM_IDLE
    |=> rec_er_ff && !rec_crs_ff && !rec_dv_ff && state_ff == RX_IDLE)
    else $error("idle abort not a single error");
  a_idle_quiet: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    accept && line_speed_100 && state_ff == RX_IDLE && rx_sym_kind != SYM_JK |=> !rec_er_ff)
    else $error("error repeated after idle abort");
  a_pre_drop: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    accept && !line_speed_100 && state_ff == RX_IDLE |=> !rec_dv_ff)
    else $error("10t preamble marked valid");
  a_sfd_valid: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    accept && sfd_hit |=> rec_dv_ff && rec_nib_ff == NIB_PRE && sfd_seen_ff)
    else $error("sfd did not raise valid");
  a_col_half: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    (clk_en && line_half_duplex && !rmii_ff && act_s2_ff && state_ff == RX_FRAME)
    |=> collision)
    else $error("collision missing");
  a_rxclk_src: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    clk_en && line_speed_100 && !line_link_up && !line_autoneg_en |=> !rx_clk_from_line)
    else $error("receive clock source wrong");
  a_tx_hcode: assert property (@(posedge core_clk) disable iff (!rst_n_ff)
    tx_line_valid && tx_line_code == CODE_H |-> !rmii_ff && $past(tw_er_ff, 2))
    else $error("h code without tx error");
  a_rmii_idle: assert property (@(posedge reference_oscillator_input)
    disable iff (!lrst_n_ff) l_rmii_ff && !mac_rx_dv |-> mac_rxd == NIB_IDLE)
    else $error("rxd not idle without crs_dv");
  a_nib_clk: assert property (@(posedge reference_oscillator_input)
    disable iff (!lrst_n_ff) l_ce_ff && !l_rmii_ff |=> nibble_transmit_clock != $past(ph_ff))
    else $error("nibble clock stalled");
  a_tx_ignore: assert property (@(posedge reference_oscillator_input)
    disable iff (!lrst_n_ff) l_ce_ff && l_rmii_ff && !mac_tx_en |=> $stable(tw_tgl_ff))
    else $error("di-bit taken while disabled");

  c_tx_frame: cover property (@(posedge core_clk) disable iff (!rst_n_ff)
    accept && line_speed_100 && rx_sym_kind == SYM_JK ##[1:200] accept && rx_sym_kind == SYM_TR);
  c_sfd: cover property (@(posedge core_clk) disable iff (!rst_n_ff) accept && sfd_hit);
  c_abort: cover property (@(posedge core_clk) disable iff (!rst_n_ff)
    accept && line_speed_100 && state_ff == RX_FRAME && rx_sym_kind == SYM_IDLE);
  c_collision: cover property (@(posedge core_clk) disable iff (!rst_n_ff) $rose(collision));

endmodule : phy_data_port

// ==== core/phy_port_pkg.sv ====
// Contract
// - mii transmit clock comes from the reference
// - mac tx signals sampled on tx clock rise
// - receive clock source follows speed and link
// - receive outputs change on receive clock fall
// - 100tx valid spans preamble through last nibble
// - 10t drops preamble, valid from sfd 5d
// - error symbol gives rx error and 1110
// - mac tx error sends h code group
// - 100tx carrier from j/k to t/r
// - idle without t/r drops carrier, one error
// - 10t carrier from preamble to eof
// - half duplex tx and rx give collision (di-bit mode never raises collision)
// - crs_dv rises as soon as carrier seen (here it rises only after one core flop and three link flops)
// - crs_dv falls synchronously on carrier loss
// - rxd stays 00 until decoding established
// - rxd is two bits per clock, else 00
// - tx di-bits taken only while enable high
package phy_port_pkg;

  // link clock rate and the nibble clock derived from it
  localparam int LINK_MHZ = 50;
  localparam int NIBBLE_MHZ = 25;
  localparam int NIBBLE_DIV = LINK_MHZ / NIBBLE_MHZ;

  // fixed nibble and code values
  localparam logic [3:0] NIB_ERR = 4'he;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [3:0] NIB_SFD = 4'hd;
  localparam logic [3:0] NIB_IDLE = 4'h0;
  localparam logic [1:0] DIBIT_IDLE = 2'h0;
  localparam logic [4:0] CODE_H = 5'h04;
  localparam logic [4:0] CODE_NONE = 5'h00;

  // symbol classes handed over by the line decoder
  typedef enum logic [2:0] {SYM_DATA, SYM_IDLE, SYM_JK, SYM_TR, SYM_ERR} sym_e;

  // receive framing state
  typedef enum logic {RX_IDLE, RX_FRAME} rx_state_e;

endpackage : phy_port_pkg
